// file: logic/tracking_position_defs.svh
// Constants for the tracking position counter: widths, timing, register map and reset values
`ifndef TRACKING_POSITION_DEFS_SVH
`define TRACKING_POSITION_DEFS_SVH

// ==========================================================
// Position word
`define POS_WIDTH       16

// ==========================================================
// Width select codes {width_select_b, width_select_a}
`define SEL_10          2'b00
`define SEL_12          2'b01
`define SEL_14          2'b10
`define SEL_16          2'b11

// Active-bit masks, MSB aligned: 1,024 / 4,096 / 16,384 / 65,536 counts per turn
`define MASK_10         16'hFFC0
`define MASK_12         16'hFFF0
`define MASK_14         16'hFFFC
`define MASK_16         16'hFFFF

// ==========================================================
// Timing
`define CLK_PERIOD_NS   10
`define WRAP_MIN_NS     300
`define WRAP_MIN_CYC    ((`WRAP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// Register map (byte addresses)
`define ADDR_POSITION   8'h00
`define ADDR_STATUS     8'h04
`define ADDR_MASK       8'h08
`define ADDR_CONTROL    8'h0C
`define ADDR_STATE      8'h10

// Status and mask bit positions
`define STAT_STEP       0
`define STAT_WRAP       1
`define STAT_REV        2
`define STATUS_W        3

// Control bit positions and reset values
`define CTRL_FREEZE     0
`define RST_STATUS      3'h0
`define RST_MASK        3'h0
`define RST_CONTROL     1'b0
`define RST_COUNT       16'h0000

`endif

// file: logic/tracking_position_pkg.sv
// Types shared by the tracking position counter
package tracking_position_pkg;

    // ==========================================================
    // Output latch freeze sequencer, Gray coded except the two-bit REFRESH to TRACK step
    typedef enum logic [1:0] {
        TRACK   = 2'b00,
        FROZEN  = 2'b01,
        REFRESH = 2'b11
    } freeze_state_t;

    // Sticky event vector {reversal, wrap, step}
    typedef logic [2:0] event_vec_t;

endpackage : tracking_position_pkg

// file: logic/sync_2ff.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] metaStage;

    // ==========================================================
    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            metaStage <= '0;
            syncOut   <= '0;
        end else begin
            metaStage <= asyncIn;
            syncOut   <= metaStage;
        end
    end

endmodule : sync_2ff

`default_nettype wire

// file: logic/pulse_stretch.sv
// Retriggerable pulse stretcher with a minimum high time
`timescale 1ns/10ps
`default_nettype none

module pulse_stretch #(
    parameter int MIN_CYC = 30
) (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic trigger,
    output var  logic pulseOut
);

    localparam int CW = $clog2(MIN_CYC + 1);

    logic [CW-1:0] remain;

    // ==========================================================
    // A trigger reloads the hold count, so a late event stretches the pulse
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            remain   <= '0;
            pulseOut <= 1'b0;
        end else if (trigger) begin
            remain   <= CW'(MIN_CYC - 1);
            pulseOut <= 1'b1;
        end else if (remain != '0) begin
            remain   <= remain - CW'(1);
        end else begin
            pulseOut <= 1'b0;
        end
    end

endmodule : pulse_stretch

`default_nettype wire

// file: logic/tracking_position_counter.sv
// Tracking position counter: step-driven up/down count, busy, wrap, direction and registers
`timescale 1ns/10ps
`default_nettype none
`include "tracking_position_defs.svh"

// Contract
// - Each loop step moves the count one LSB up or down, no command needed.
// - Every single-step count change produces one busy pulse.
// - Position is plain natural binary, zero angle reads all zeros.
// - Wrap pulse rises when count crosses all ones and all zeros either way.
// - Direction output is already valid before the wrap pulse rises.
// - Direction is latched and changes only on an actual one-LSB reversal.
// - Wrap pulse and direction keep working while latch freeze is asserted.
// - Counter modulus is 1,024, 4,096, 16,384 or 65,536 by width.
// - Two width select levels choose 10, 12, 14 or 16 bit resolution.
// - Freeze stops latch updates but not tracking; release gives a refresh busy pulse.
// - Each wrap pulse stays high at least 300 ns.
module tracking_position_counter
    import tracking_position_pkg::*;
#(
    parameter int WRAP_CYC = `WRAP_MIN_CYC
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        vcoStep,
    input  wire logic        vcoUp,
    input  wire logic        width_select_a,
    input  wire logic        width_select_b,
    input  wire logic        latchFreeze,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output var  logic [31:0] regRdata,
    output var  logic [15:0] position,
    output var  logic        busy,
    output var  logic        direction,
    output var  logic        turn_wrap_pulse,
    output var  logic        irq
);

    // ==========================================================
    // Width decoding, shared by the counter and the step size
    function automatic logic [15:0] widthMask(input logic [1:0] sel);
        case (sel)
            `SEL_10: widthMask = `MASK_10;
            `SEL_12: widthMask = `MASK_12;
            `SEL_14: widthMask = `MASK_14;
            default: widthMask = `MASK_16;
        endcase
    endfunction : widthMask

    // One LSB of the selected width, MSB aligned
    function automatic logic [15:0] stepSize(input logic [1:0] sel);
        stepSize = ~widthMask(sel) + 16'h0001;
    endfunction : stepSize

    // ==========================================================
    // Declarations
    logic [4:0]    syncBus;
    logic          syncStep;
    logic          syncUp;
    logic          syncFreeze;
    logic [1:0]    widthSel;
    logic          stepPrev;
    logic          stepEvt;
    logic [15:0]   mask;
    logic [15:0]   stepSz;
    logic [15:0]   count;
    logic [15:0]   next_count;
    logic          wrapNow;
    logic          wrapEvt;
    logic          reversal;
    logic          softFreeze;
    logic          freezeReq;
    freeze_state_t frzState;
    freeze_state_t next_frzState;
    event_vec_t    status;
    event_vec_t    intMask;
    event_vec_t    events;
    event_vec_t    clearBits;
    logic [7:0]    wrapRun;

    // ==========================================================
    // Pin synchronisation: the step, sense, width and freeze pins are outside the clock domain
    sync_2ff #(
        .WIDTH (5)
    ) u_sync (
        .clock   (clock),
        .rstn    (rstn),
        .asyncIn ({latchFreeze, width_select_b, width_select_a, vcoUp, vcoStep}),
        .syncOut (syncBus)
    );

    assign syncStep   = syncBus[0];
    assign syncUp     = syncBus[1];
    assign widthSel   = syncBus[3:2];
    assign syncFreeze = syncBus[4];
    assign freezeReq  = syncFreeze | softFreeze;

    // Edge detect on the synchronised step; VCO steps are far slower than the clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stepPrev <= 1'b0;
        end else begin
            stepPrev <= syncStep;
        end
    end

    assign stepEvt = syncStep & ~stepPrev;
    assign mask    = widthMask(widthSel);
    assign stepSz  = stepSize(widthSel);

    // ==========================================================
    // Up/down counter; unused low bits always cleared, so a 16-bit add wraps at the width
    always_comb begin
        next_count = count & mask;
        wrapNow    = 1'b0;
        if (stepEvt) begin
            if (syncUp) begin
                next_count = (count & mask) + stepSz;
                wrapNow    = ((count & mask) == mask);
            end else begin
                next_count = (count & mask) - stepSz;
                wrapNow    = ((count & mask) == 16'h0000);
            end
        end
    end

    // Count register in natural binary
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= `RST_COUNT;
        end else begin
            count <= next_count;
        end
    end

    // ==========================================================
    // Direction latch: only a step against the held sense flips it
    assign reversal = stepEvt & (syncUp != direction);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            direction <= 1'b1;
        end else if (reversal) begin
            direction <= syncUp;
        end
    end

    // Wrap event flop delays the pulse one cycle behind the direction update
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrapEvt <= 1'b0;
        end else begin
            wrapEvt <= wrapNow;
        end
    end

    // Freeze has no say here, so revolution counting never misses a turn
    pulse_stretch #(
        .MIN_CYC (WRAP_CYC)
    ) u_wrap (
        .clock    (clock),
        .rstn     (rstn),
        .trigger  (wrapEvt),
        .pulseOut (turn_wrap_pulse)
    );

    // ==========================================================
    // Freeze sequencer: a release passes through REFRESH for one cycle
    always_comb begin
        case (frzState)
            TRACK:   next_frzState = freezeReq ? FROZEN : TRACK;
            FROZEN:  next_frzState = freezeReq ? FROZEN : REFRESH;
            REFRESH: next_frzState = freezeReq ? FROZEN : TRACK;
            default: next_frzState = TRACK;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frzState <= TRACK;
        end else begin
            frzState <= next_frzState;
        end
    end

    // Output latch follows the counter except while frozen
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            position <= `RST_COUNT;
        end else if (frzState != FROZEN) begin
            position <= next_count;
        end
    end

    // Busy marks each step and the refresh after a freeze release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else begin
            busy <= stepEvt | (frzState == REFRESH);
        end
    end

    // ==========================================================
    // Registers: sticky status, write one to clear; an event in the same cycle wins
    assign events    = {reversal, wrapNow, stepEvt};
    assign clearBits = (regWrite && regAddr == `ADDR_STATUS) ? regWdata[`STATUS_W-1:0] : `RST_STATUS;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status <= `RST_STATUS;
        end else begin
            status <= (status & ~clearBits) | events;
        end
    end

    // Mask and control registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            intMask    <= `RST_MASK;
            softFreeze <= `RST_CONTROL;
        end else if (regWrite) begin
            if (regAddr == `ADDR_MASK) begin
                intMask <= regWdata[`STATUS_W-1:0];
            end
            if (regAddr == `ADDR_CONTROL) begin
                softFreeze <= regWdata[`CTRL_FREEZE];
            end
        end
    end

    // Read data stand one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                `ADDR_POSITION: regRdata <= {16'h0000, count};
                `ADDR_STATUS:   regRdata <= {29'h0000_0000, status};
                `ADDR_MASK:     regRdata <= {29'h0000_0000, intMask};
                `ADDR_CONTROL:  regRdata <= {31'h0000_0000, softFreeze};
                `ADDR_STATE:    regRdata <= {28'h000_0000, widthSel, frzState == FROZEN, direction};
                default:        regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    // Level interrupt from a flop; lags the status by one cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & intMask);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Length of the current wrap pulse, saturating
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrapRun <= 8'h00;
        end else if (!turn_wrap_pulse) begin
            wrapRun <= 8'h00;
        end else if (wrapRun != 8'hFF) begin
            wrapRun <= wrapRun + 8'h01;
        end
    end

    property p_no_step_hold;
        (!stepEvt && mask == $past(mask)) |=> $stable(count);
    endproperty
    a_no_step_hold: assert property (p_no_step_hold) else $error("count moved without a step");

    property p_step_busy;
        stepEvt |=> busy ##1 !busy;
    endproperty
    a_step_busy: assert property (p_step_busy) else $error("step without one busy pulse");

    property p_busy_cause;
        busy |-> ($past(stepEvt) || $past(frzState) == REFRESH);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without a cause");

    property p_wrap_up;
        (stepEvt && syncUp && (count & mask) == mask) |=> count == 16'h0000 ##1 turn_wrap_pulse;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("no wrap on all ones to zero");

    property p_modulus_down;
        (stepEvt && !syncUp && (count & mask) == 16'h0000 && $stable(mask)) |=> count == mask ##1 turn_wrap_pulse;
    endproperty
    a_modulus_down: assert property (p_modulus_down) else $error("down wrap not to all ones");

    property p_dir_before_wrap;
        $rose(turn_wrap_pulse) |-> direction == $past(direction);
    endproperty
    a_dir_before_wrap: assert property (p_dir_before_wrap) else $error("direction late for wrap");

    property p_dir_reversal;
        $changed(direction) |-> ($past(stepEvt) && $past(syncUp) == direction);
    endproperty
    a_dir_reversal: assert property (p_dir_reversal) else $error("direction changed without reversal");

    property p_wrap_in_freeze;
        (wrapEvt && frzState != TRACK) |=> turn_wrap_pulse;
    endproperty
    a_wrap_in_freeze: assert property (p_wrap_in_freeze) else $error("wrap lost while frozen");

    property p_frozen_hold;
        frzState == FROZEN |=> $stable(position);
    endproperty
    a_frozen_hold: assert property (p_frozen_hold) else $error("latch moved while frozen");

    property p_refresh;
        frzState == REFRESH |=> busy && position == $past(next_count);
    endproperty
    a_refresh: assert property (p_refresh) else $error("release gave no refresh");

    property p_wrap_width;
        $fell(turn_wrap_pulse) |-> $past(wrapRun) >= WRAP_CYC - 1;
    endproperty
    a_wrap_width: assert property (p_wrap_width) else $error("wrap pulse too short");

    property p_low_bits_zero;
        (count & ~mask) == 16'h0000 || $changed(mask);
    endproperty
    a_low_bits_zero: assert property (p_low_bits_zero) else $error("unused low bits set");

    c_step_up:   cover property (stepEvt && syncUp);
    c_wrap:      cover property ($rose(turn_wrap_pulse));
    c_refresh:   cover property (frzState == REFRESH);
    c_reversal:  cover property (reversal);

endmodule : tracking_position_counter

`default_nettype wire

// file: tb/host_model.sv
// Host-side model: sets width pins while busy is low and watches busy, wrap and direction
`timescale 1ns/10ps
`default_nettype none

module host_model (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       busy,
    input  wire logic       direction,
    input  wire logic       turn_wrap_pulse,
    input  wire logic [1:0] widthReq,
    output var  logic       width_select_a,
    output var  logic       width_select_b
);
    int   busyCount;
    int   wrapCount;
    int   wrapLen;
    int   wrapMin;
    logic dirAtWrap;
    logic wrapPrev;

    // ==========================================================
    // Width pins
    // Moved only in a quiet cycle, so a change never lands while data moves
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {width_select_b, width_select_a} <= 2'b11;
        end else if (busy !== 1'b1) begin
            {width_select_b, width_select_a} <= widthReq;
        end
    end

    // ==========================================================
    // Observation of busy pulses, wrap rises and wrap hold time
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busyCount = 0;
            wrapCount = 0;
            wrapLen   = 0;
            wrapMin   = 1000;
            wrapPrev  = 1'b0;
        end else begin
            if (busy === 1'b1) busyCount++;
            if (turn_wrap_pulse === 1'b1) begin
                if (wrapPrev !== 1'b1) begin
                    wrapCount++;
                    dirAtWrap = direction; // Sense seen at the first high cycle
                end
                wrapLen++;
            end else if (wrapPrev === 1'b1) begin
                if (wrapLen < wrapMin) wrapMin = wrapLen;
                wrapLen = 0;
            end
            wrapPrev = turn_wrap_pulse;
        end
    end
endmodule : host_model

`default_nettype wire

// file: tb/tb_tracking_position_counter.sv
// Self-checking bench for the tracking position counter
`timescale 1ns/10ps
`default_nettype none
`include "tracking_position_defs.svh"

module tb_tracking_position_counter;
    logic        clock, rstn, vcoStep, vcoUp, latchFreeze, regWrite, regRead;
    logic        width_select_a, width_select_b, busy, direction, turn_wrap_pulse, irq;
    logic [1:0]  widthReq;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, rd, rnd;
    logic [15:0] position, expPos, expLatch;
    logic        expDir, softFreeze;
    int          err_total, n_compared, seed, busyExp, wrapExp;

    tracking_position_counter u_dut (.clock(clock), .rstn(rstn), .vcoStep(vcoStep), .vcoUp(vcoUp),
        .width_select_a(width_select_a), .width_select_b(width_select_b), .latchFreeze(latchFreeze),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .position(position), .busy(busy), .direction(direction),
        .turn_wrap_pulse(turn_wrap_pulse), .irq(irq));
    host_model u_host (.clock(clock), .rstn(rstn), .busy(busy), .direction(direction),
        .turn_wrap_pulse(turn_wrap_pulse), .widthReq(widthReq),
        .width_select_a(width_select_a), .width_select_b(width_select_b));

    // ==========================================================
    // Helpers
    always #5 clock = ~clock;

    function automatic logic [15:0] width_mask(input logic [1:0] w);
        case (w)
            `SEL_10: return `MASK_10;
            `SEL_12: return `MASK_12;
            `SEL_14: return `MASK_14;
            default: return `MASK_16;
        endcase
    endfunction : width_mask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // Bus strobes end one step after the edge so back-to-back calls never double-assign
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        #1;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : reg_rd

    // One VCO step; sense is set up 4 clocks early and both levels last 3 clocks or more
    task automatic do_step(input logic up);
        logic [15:0] m;
        logic        wrapped;
        m = width_mask(widthReq);
        vcoUp <= up;
        repeat (4) @(posedge clock);
        vcoStep <= 1'b1;
        repeat (3) @(posedge clock);
        vcoStep <= 1'b0;
        repeat (4) @(posedge clock);
        wrapped = (up && expPos == m) || (!up && expPos == 16'h0000);
        expPos = up ? expPos + (~m + 16'h0001) : expPos - (~m + 16'h0001);
        expDir = up;
        busyExp++;
        if (!(latchFreeze || softFreeze)) expLatch = expPos;
        if (wrapped) wrapExp++;
        #1;
        check("position", position, expLatch);
        check("direction", direction, expDir);
        check("busy pulses", busyCount(), busyExp);
        check("wrap pulses", u_host.wrapCount, wrapExp);
        if (wrapped) begin
            check("sense at wrap", u_host.dirAtWrap, up);
            repeat (40) @(posedge clock); // Let the wrap hold run out before the next one
            #1;
        end
    endtask : do_step

    function automatic int busyCount();
        return u_host.busyCount;
    endfunction : busyCount

    task automatic set_width(input logic [1:0] w);
        widthReq <= w;
        repeat (8) @(posedge clock);
        #1;
        expPos = expPos & width_mask(w);
        expLatch = expLatch & width_mask(w);
        check("position after width change", position, expLatch);
    endtask : set_width

    // ==========================================================
    // Main sequence
    initial begin
        clock = 0; rstn = 0; vcoStep = 0; vcoUp = 1; latchFreeze = 0; widthReq = `SEL_16;
        regAddr = 0; regWdata = 0; regWrite = 0; regRead = 0; softFreeze = 0; seed = 99;
        err_total = 0; n_compared = 0; expPos = 0; expLatch = 0; expDir = 1; busyExp = 0; wrapExp = 0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        #1;
        check("position", position, `RST_COUNT);
        check("outputs", {busy, direction, turn_wrap_pulse, irq}, 4'b0100);
        reg_rd(`ADDR_STATUS, rd);
        check("status", rd, `RST_STATUS);
        // Every width: across zero downwards, then back up
        for (int w = 0; w < 4; w++) begin
            set_width(w[1:0]);
            do_step(1'b0);
            check("all ones", position, width_mask(w[1:0]));
            do_step(1'b1);
        end
        // Frozen latch: tracking, reversal and wrap go on
        latchFreeze <= 1'b1;
        repeat (5) @(posedge clock);
        do_step(1'b1);
        do_step(1'b0);
        do_step(1'b0);
        reg_rd(`ADDR_POSITION, rd);
        check("live count", rd, {16'h0000, expPos});
        latchFreeze <= 1'b0;
        repeat (6) @(posedge clock);
        #1;
        busyExp++;
        expLatch = expPos;
        check("refresh busy", busyCount(), busyExp);
        check("refreshed position", position, expLatch);
        do_step(1'b1);
        // Sticky events, mask and interrupt
        reg_rd(`ADDR_STATUS, rd);
        check("status", rd, 32'h0000_0007);
        reg_wr(`ADDR_MASK, 32'h0000_0002);
        repeat (2) @(posedge clock);
        #1 check("irq", irq, 1'b1);
        reg_wr(`ADDR_STATUS, 32'h0000_0002);
        reg_rd(`ADDR_STATUS, rd);
        check("status", rd, 32'h0000_0005);
        check("irq", irq, 1'b0);
        reg_wr(`ADDR_MASK, 32'h0000_0005);
        reg_wr(8'h24, 32'hFFFF_FFFF);
        reg_rd(`ADDR_MASK, rd);
        check("mask", rd, 32'h0000_0005);
        check("irq", irq, 1'b1);
        reg_wr(`ADDR_STATUS, 32'h0000_0007);
        reg_rd(8'h20, rd);
        check("unmapped", rd, 32'h0000_0000);
        check("irq", irq, 1'b0);
        // Soft freeze through the control register
        reg_wr(`ADDR_CONTROL, 32'h0000_0001);
        softFreeze = 1'b1;
        @(posedge clock); // Sequencer reaches the frozen state one edge after the write lands
        #1;
        reg_rd(`ADDR_STATE, rd);
        check("state", rd, {28'h0, 2'b11, 1'b1, expDir});
        do_step(1'b0);
        reg_wr(`ADDR_CONTROL, 32'h0000_0000);
        softFreeze = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        busyExp++;
        expLatch = expPos;
        check("refreshed position", position, expLatch);
        // Random walk at 16 bits, then a narrow width clears low bits
        for (int i = 0; i < 40; i++) begin
            rnd = $random(seed);
            do_step(rnd[0]);
        end
        set_width(`SEL_10);
        for (int i = 0; i < 10; i++) begin
            rnd = $random(seed);
            do_step(rnd[0]);
        end
        set_width(`SEL_16);
        check("wrap hold", u_host.wrapMin >= `WRAP_MIN_CYC, 1'b1);
        end_of_test();
    end

    // Watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        end_of_test();
    end
endmodule : tb_tracking_position_counter

`default_nettype wire
